// >>> inc/diag_report_consts.svh
`ifndef DIAG_REPORT_CONSTS_SVH
`define DIAG_REPORT_CONSTS_SVH

// status codes placed on the status code field
`define CODE_READY          10'h01E7
`define CODE_DEFECT         10'h01F4
`define CODE_FIELD_RANGE    10'h01EB
`define CODE_OVERVOLTAGE    10'h01EA
`define CODE_UNDERVOLTAGE   10'h01EC
`define CODE_OFFSET_COMP    10'h01ED

// failure detail field bit positions
`define DETAIL_ARITH_BIT    0
`define DETAIL_CHANNEL_BIT  1
`define DETAIL_MEMORY_BIT   2
`define DETAIL_HALL_BIT     3
`define DETAIL_WATCHDOG_BIT 4

// signature engine
`define SIG_BYTE_COUNT      30
`define SIG_POLY            8'h1D
`define SIG_RESET           8'h00

// register offsets of the plain register port
`define REG_CTRL            4'h0
`define REG_STATUS          4'h1
`define REG_SIG_DATA        4'h2
`define REG_SIG_RESULT      4'h3
`define REG_LATCHED         4'h4

// control register fields
`define CTRL_PHASE_LSB      0
`define CTRL_EXTENDED_BIT   2
`define CTRL_SIG_START_BIT  3
`define CTRL_ECU_RESET_BIT  4
`define CTRL_RESET_VALUE    8'h00

`endif

// >>> inc/diag_report_pkg.sv
package diag_report_pkg;

  typedef enum logic [1:0]
  {
    phase_init_1   = 2'h0,
    phase_init_2   = 2'h1,
    phase_init_3   = 2'h2,
    phase_run      = 2'h3
  } link_phase_t;

  typedef struct packed
  {
    logic watchdog;
    logic regulated_supply_low;
    logic below_por;
    logic reverse_polarity;
    logic arith_overflow;
    logic memory_checksum_fault;
    logic hall_broken;
    logic channel_broken;
    logic field_out_of_range;
    logic overvoltage;
    logic undervoltage;
    logic offset_comp;
  } fault_flags_t;

  typedef struct packed
  {
    logic       force_low;
    logic       error_flag;
    logic [9:0] status_code;
    logic [5:0] failure_detail;
  } frame_fields_t;

  typedef enum logic [2:0]
  {
    sig_idle = 3'b001,
    sig_run  = 3'b010,
    sig_done = 3'b100
  } sig_state_t;

endpackage : diag_report_pkg

// >>> hdl/signature_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "diag_report_consts.svh"

// byte-serial signature register used by the memory self-test
module signature_engine
#(
  parameter int unsigned BYTE_COUNT = `SIG_BYTE_COUNT
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  // control
  input  wire logic       start,
  input  wire logic       byte_valid,
  input  wire logic [7:0] byte_data,
  // result
  output logic      [7:0] signature,
  output logic            done
);

  diag_report_pkg::sig_state_t state_q;
  diag_report_pkg::sig_state_t state_d;
  logic [7:0]                  misr_q;
  logic [7:0]                  misr_d;
  logic [4:0]                  count_q;
  logic [4:0]                  count_d;
  logic                        done_q;
  logic                        done_d;

  assign signature = misr_q;
  assign done      = done_q;

  always_comb
  begin
    state_d = state_q;
    misr_d  = misr_q;
    count_d = count_q;
    done_d  = done_q;
    unique case (state_q)
      diag_report_pkg::sig_idle,
      diag_report_pkg::sig_done:
      begin
        if (start)
        begin
          state_d = diag_report_pkg::sig_run;
          misr_d  = `SIG_RESET;
          count_d = 5'h00;
          done_d  = 1'b0;
        end
      end
      diag_report_pkg::sig_run:
      begin
        if (byte_valid)
        begin
          // shift, fold in the byte, and add the feedback when bit 7 drops out
          misr_d = {misr_q[6:0], 1'b0} ^ byte_data ^ (misr_q[7] ? `SIG_POLY : 8'h00);
          count_d = count_q + 5'h01;
          if (count_q == 5'(BYTE_COUNT - 1))
          begin
            state_d = diag_report_pkg::sig_done;
            done_d  = 1'b1;
          end
        end
      end
      default:
      begin
        state_d = diag_report_pkg::sig_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= diag_report_pkg::sig_idle;
      misr_q  <= `SIG_RESET;
      count_q <= 5'h00;
      done_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      misr_q  <= misr_d;
      count_q <= count_d;
      done_q  <= done_d;
    end
  end

endmodule : signature_engine
`default_nettype wire

// >>> hdl/diag_error_reporter.sv
`timescale 1ns/10ps
`default_nettype none
`include "diag_report_consts.svh"

module diag_error_reporter
(
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst_b,
  input  wire logic                           clk_en,
  // fault flags from sensor core and analog side
  input  wire diag_report_pkg::fault_flags_t  fault_in,
  // link framer side
  input  wire logic                           frame_start,
  input  wire logic                           phase3_done,
  input  wire logic                           framer_tx_bit,
  input  wire logic [2:0]                     framer_counter_bits,
  input  wire logic [9:0]                     sensor_data,
  // register port
  input  wire logic [3:0]                     reg_addr,
  input  wire logic [7:0]                     reg_wdata,
  input  wire logic                           reg_write,
  input  wire logic                           reg_read,
  output logic      [7:0]                     reg_rdata,
  // frame contents and serial line
  output diag_report_pkg::frame_fields_t      frame_fields,
  output logic [2:0]                          frame_counter_bits,
  output logic                                link_tx_bit,
  output logic                                run_mode
);

  diag_report_pkg::fault_flags_t  sync1_q;
  diag_report_pkg::fault_flags_t  sync2_q;
  diag_report_pkg::fault_flags_t  flags;
  diag_report_pkg::frame_fields_t fields_q;
  diag_report_pkg::frame_fields_t fields_d;
  diag_report_pkg::link_phase_t   phase_q;
  diag_report_pkg::link_phase_t   phase_d;

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic       defect_q;
  logic       defect_d;
  logic       masked_q;
  logic       masked_d;
  logic [5:0] detail_q;
  logic [5:0] detail_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       tx_q;
  logic       tx_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       sig_start_q;
  logic       sig_start_d;
  logic       sig_valid_q;
  logic       sig_valid_d;
  logic [7:0] sig_byte_q;
  logic [7:0] sig_byte_d;
  logic [7:0] signature;
  logic       sig_done;
  logic       force_low;
  logic       internal_fault;
  logic       other_fault;
  logic [5:0] detail_now;
  logic       ecu_reset;
  logic       run_q;
  logic       run_d;

  assign frame_fields       = fields_q;
  assign frame_counter_bits = cnt_q;
  assign link_tx_bit        = tx_q;
  assign reg_rdata          = rdata_q;
  assign run_mode           = run_q;

  // analog flags pass two flops; only the second stage is looked at
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (clk_en)
    begin
      sync1_q <= fault_in;
      sync2_q <= sync1_q;
    end
  end

  always_comb
  begin
    flags             = sync2_q;
    flags.hall_broken = 1'b0;
  end

  assign force_low = flags.watchdog
                   | flags.regulated_supply_low
                   | flags.below_por
                   | flags.reverse_polarity;

  assign internal_fault = flags.arith_overflow | flags.memory_checksum_fault
                        | flags.hall_broken | flags.channel_broken
                        | flags.watchdog;

  assign other_fault = flags.field_out_of_range | flags.overvoltage
                     | flags.undervoltage | flags.offset_comp;

  always_comb
  begin
    detail_now                          = 6'h00;
    detail_now[`DETAIL_ARITH_BIT]       = flags.arith_overflow;
    detail_now[`DETAIL_CHANNEL_BIT]     = flags.channel_broken;
    detail_now[`DETAIL_MEMORY_BIT]      = flags.memory_checksum_fault;
    detail_now[`DETAIL_HALL_BIT]        = flags.hall_broken;
    detail_now[`DETAIL_WATCHDOG_BIT]    = flags.watchdog;
  end

  assign ecu_reset = reg_write && (reg_addr == `REG_CTRL)
                   && reg_wdata[`CTRL_ECU_RESET_BIT];

  // phase, latched defect and masking state
  always_comb
  begin
    phase_d  = phase_q;
    defect_d = defect_q;
    masked_d = masked_q;
    detail_d = detail_q | detail_now;
    unique case (phase_q)
      diag_report_pkg::phase_init_1,
      diag_report_pkg::phase_init_2:
      begin
        // faults here are remembered but not shown until phase III
        if (internal_fault | other_fault)
          masked_d = 1'b1;
        if (flags.memory_checksum_fault)
          defect_d = 1'b1;
        if (frame_start && phase_q == diag_report_pkg::phase_init_1)
          phase_d = diag_report_pkg::phase_init_2;
        else if (frame_start)
          phase_d = diag_report_pkg::phase_init_3;
      end
      diag_report_pkg::phase_init_3:
      begin
        if (internal_fault)
          defect_d = 1'b1;
        if (masked_q)
          defect_d = 1'b1;
        // a defective part stays in phase III until power is removed
        if (phase3_done && !defect_d)
          phase_d = diag_report_pkg::phase_run;
      end
      diag_report_pkg::phase_run:
      begin
        if (internal_fault)
          defect_d = 1'b1;
        else if (ecu_reset)
        begin
          defect_d = 1'b0;
          detail_d = 6'h00;
        end
      end
      default:
      begin
        phase_d = diag_report_pkg::phase_init_1;
      end
    endcase
    run_d = (phase_d == diag_report_pkg::phase_run);
  end

  // frame contents only change at a frame boundary, except force_low, which a fault sets at once
  always_comb
  begin
    fields_d = fields_q;
    tx_d     = force_low ? 1'b0 : framer_tx_bit;
    cnt_d    = framer_counter_bits;
    if (frame_start)
    begin
      fields_d.force_low      = force_low;
      fields_d.error_flag     = 1'b0;
      fields_d.status_code    = sensor_data;
      fields_d.failure_detail = 6'h00;
      if (phase_q == diag_report_pkg::phase_init_3)
      begin
        fields_d.status_code = (defect_q | masked_q) ? `CODE_DEFECT : `CODE_READY;
        fields_d.error_flag  = defect_q | masked_q;
      end
      else if (phase_q == diag_report_pkg::phase_run)
      begin
        if (defect_q | internal_fault)
        begin
          fields_d.status_code = `CODE_DEFECT;
          fields_d.error_flag  = 1'b1;
          if (ctrl_q[`CTRL_EXTENDED_BIT])
            fields_d.failure_detail = detail_q | detail_now;
        end
        else if (flags.field_out_of_range)
        begin
          fields_d.status_code = `CODE_FIELD_RANGE;
          fields_d.error_flag  = 1'b1;
        end
        else if (flags.overvoltage)
        begin
          fields_d.status_code = `CODE_OVERVOLTAGE;
          fields_d.error_flag  = 1'b1;
        end
        else if (flags.undervoltage)
        begin
          fields_d.status_code = `CODE_UNDERVOLTAGE;
          fields_d.error_flag  = 1'b1;
        end
        else if (flags.offset_comp)
        begin
          fields_d.status_code = `CODE_OFFSET_COMP;
          fields_d.error_flag  = 1'b1;
        end
      end
    end
    else if (force_low)
      fields_d.force_low = 1'b1;
  end

  // register port and signature feed
  always_comb
  begin
    ctrl_d      = ctrl_q;
    rdata_d     = 8'h00;
    sig_start_d = 1'b0;
    sig_valid_d = 1'b0;
    sig_byte_d  = sig_byte_q;
    if (reg_write)
    begin
      unique case (reg_addr)
        `REG_CTRL:
        begin
          ctrl_d      = reg_wdata & 8'h07;
          sig_start_d = reg_wdata[`CTRL_SIG_START_BIT];
        end
        `REG_SIG_DATA:
        begin
          sig_valid_d = 1'b1;
          sig_byte_d  = reg_wdata;
        end
        default:
        begin
        end
      endcase
    end
    if (reg_read)
    begin
      unique case (reg_addr)
        `REG_CTRL:       rdata_d = ctrl_q;
        `REG_STATUS:     rdata_d = {sig_done, run_mode, masked_q, defect_q,
                                    force_low, phase_q, tx_q};
        `REG_SIG_RESULT: rdata_d = signature;
        `REG_LATCHED:    rdata_d = {2'b00, detail_q};
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_q     <= diag_report_pkg::phase_init_1;
      defect_q    <= 1'b0;
      masked_q    <= 1'b0;
      detail_q    <= 6'h00;
      fields_q    <= '0;
      tx_q        <= 1'b0;
      cnt_q       <= 3'h0;
      ctrl_q      <= `CTRL_RESET_VALUE;
      rdata_q     <= 8'h00;
      sig_start_q <= 1'b0;
      sig_valid_q <= 1'b0;
      sig_byte_q  <= 8'h00;
      run_q       <= 1'b0;
    end
    else if (clk_en)
    begin
      phase_q     <= phase_d;
      defect_q    <= defect_d;
      masked_q    <= masked_d;
      detail_q    <= detail_d;
      fields_q    <= fields_d;
      tx_q        <= tx_d;
      cnt_q       <= cnt_d;
      ctrl_q      <= ctrl_d;
      rdata_q     <= rdata_d;
      sig_start_q <= sig_start_d;
      sig_valid_q <= sig_valid_d;
      sig_byte_q  <= sig_byte_d;
      run_q       <= run_d;
    end
  end

  signature_engine
  #(
    .BYTE_COUNT (`SIG_BYTE_COUNT)
  )
  u_signature
  (
    .core_clk   (core_clk),
    .rst_b      (rst_b),
    .clk_en     (clk_en),
    .start      (sig_start_q),
    .byte_valid (sig_valid_q),
    .byte_data  (sig_byte_q),
    .signature  (signature),
    .done       (sig_done)
  );

endmodule : diag_error_reporter
`default_nettype wire

// >>> verification/diag_error_reporter_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "diag_report_consts.svh"

module diag_error_reporter_monitor
(
  // clock and reset
  input wire logic                           core_clk,
  input wire logic                           rst_b,
  input wire logic                           clk_en,
  // faults and framer
  input wire diag_report_pkg::fault_flags_t  fault_in,
  input wire logic                           frame_start,
  input wire logic                           phase3_done,
  input wire logic                           framer_tx_bit,
  input wire logic [2:0]                     framer_counter_bits,
  input wire logic [9:0]                     sensor_data,
  // register port
  input wire logic [3:0]                     reg_addr,
  input wire logic [7:0]                     reg_wdata,
  input wire logic                           reg_write,
  input wire logic                           reg_read,
  input wire logic [7:0]                     reg_rdata,
  // outputs
  input wire diag_report_pkg::frame_fields_t frame_fields,
  input wire logic [2:0]                     frame_counter_bits,
  input wire logic                           link_tx_bit,
  input wire logic                           run_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // two sync stages plus the output flop
  sequence wd_held;
    fault_in.watchdog [*3];
  endsequence

  sequence defect_sent;
    !run_mode ##0 frame_fields.status_code == `CODE_DEFECT;
  endsequence

  a_watchdog_low: assert property (wd_held |=> !link_tx_bit)
    else $error("line not low under watchdog fault");
  a_supply_low: assert property (fault_in.regulated_supply_low [*3] |=> !link_tx_bit)
    else $error("line not low under regulated supply fault");
  a_por_low: assert property (fault_in.below_por [*3] |=> !link_tx_bit)
    else $error("line not low below power-on threshold");
  a_defect_flag: assert property (run_mode && frame_fields.status_code == `CODE_DEFECT |-> frame_fields.error_flag)
    else $error("defect code without error flag");
  a_counter_kept: assert property (frame_fields.error_flag |-> frame_counter_bits == $past(framer_counter_bits))
    else $error("frame counter disturbed during error");
  a_hall_silent: assert property (!frame_fields.failure_detail[`DETAIL_HALL_BIT])
    else $error("hall detail bit reported");
  a_defect_no_run: assert property (defect_sent |=> !run_mode)
    else $error("defective device entered run mode");
  a_run_stays: assert property (run_mode |=> run_mode)
    else $error("run mode left without reset");
  a_fields_hold: assert property (!$past(frame_start) |-> $stable(frame_fields.status_code) && $stable(frame_fields.error_flag))
    else $error("frame contents changed mid-frame");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : diag_error_reporter_monitor

bind diag_error_reporter diag_error_reporter_monitor i_mon
(
  .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .fault_in(fault_in),
  .frame_start(frame_start), .phase3_done(phase3_done), .framer_tx_bit(framer_tx_bit),
  .framer_counter_bits(framer_counter_bits), .sensor_data(sensor_data),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .frame_fields(frame_fields), .frame_counter_bits(frame_counter_bits),
  .link_tx_bit(link_tx_bit), .run_mode(run_mode)
);

`default_nettype wire

// >>> verification/ecu_receiver_model.sv
`timescale 1ns/10ps
`default_nettype none

// far-side receiver: takes each frame's contents once they have settled
module ecu_receiver_model
(
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst_b,
  // link side
  input  wire logic                           frame_start,
  input  wire diag_report_pkg::frame_fields_t frame_fields,
  // decoded frame
  output diag_report_pkg::frame_fields_t      rx_fields
);
  logic                           seen_q;
  logic                           seen_d;
  diag_report_pkg::frame_fields_t rx_d;

  always_comb
  begin
    seen_d = frame_start;
    rx_d   = seen_q ? frame_fields : rx_fields;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seen_q    <= 1'b0;
      rx_fields <= '0;
    end
    else
    begin
      seen_q    <= seen_d;
      rx_fields <= rx_d;
    end
  end
endmodule : ecu_receiver_model

`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "diag_report_consts.svh"

module tb_top;
  logic                           core_clk = 1'b0;
  logic                           rst_b = 1'b0;
  logic                           clk_en = 1'b1;
  diag_report_pkg::fault_flags_t  fault_in = '0;
  logic                           frame_start = 1'b0;
  logic                           phase3_done = 1'b0;
  logic                           framer_tx_bit = 1'b1;
  logic [2:0]                     framer_counter_bits = 3'h0;
  logic [9:0]                     sensor_data = 10'h0123;
  logic [3:0]                     reg_addr = 4'h0;
  logic [7:0]                     reg_wdata = 8'h00;
  logic                           reg_write = 1'b0;
  logic                           reg_read = 1'b0;
  logic [7:0]                     reg_rdata;
  diag_report_pkg::frame_fields_t frame_fields;
  diag_report_pkg::frame_fields_t rx;
  logic [2:0]                     frame_counter_bits;
  logic                           link_tx_bit;
  logic                           run_mode;
  int                             fails = 0;
  int                             total_checks = 0;
  logic [7:0]                     misr;
  logic [7:0]                     b;
  logic [11:0]                    fm [6];
  logic [9:0]                     cm [6];

  always #2.5 core_clk = ~core_clk;

  diag_error_reporter i_dut
  (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .fault_in(fault_in),
    .frame_start(frame_start), .phase3_done(phase3_done), .framer_tx_bit(framer_tx_bit),
    .framer_counter_bits(framer_counter_bits), .sensor_data(sensor_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .frame_fields(frame_fields), .frame_counter_bits(frame_counter_bits),
    .link_tx_bit(link_tx_bit), .run_mode(run_mode)
  );

  ecu_receiver_model i_ecu
  (
    .core_clk(core_clk), .rst_b(rst_b), .frame_start(frame_start),
    .frame_fields(frame_fields), .rx_fields(rx)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
      fails++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask : rd

  // flags need two sync stages, so hold each setting a few cycles
  task automatic fset(input logic [11:0] f);
    @(posedge core_clk);
    fault_in <= diag_report_pkg::fault_flags_t'(f);
    tick(5);
  endtask : fset

  task automatic frame();
    @(posedge core_clk);
    frame_start         <= 1'b1;
    framer_counter_bits <= framer_counter_bits + 3'h1;
    @(posedge core_clk);
    frame_start <= 1'b0;
    tick(3);
  endtask : frame

  task automatic do_reset();
    @(posedge core_clk);
    rst_b    <= 1'b0;
    fault_in <= '0;
    tick(8);
    chk("reset fields", 18'h0_0000, frame_fields);
    chk("reset line", 1'b0, link_tx_bit);
    rst_b <= 1'b1;
  endtask : do_reset

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    results();
  end

  initial
  begin
    fm = '{12'h008, 12'h004, 12'h002, 12'h001, 12'h00C, 12'h020};
    cm = '{`CODE_FIELD_RANGE, `CODE_OVERVOLTAGE, `CODE_UNDERVOLTAGE, `CODE_OFFSET_COMP,
           `CODE_FIELD_RANGE, 10'h0123};
    // runs: checksum fault held, short fault in phase one, clean start
    for (int k = 0; k < 3; k++)
    begin
      do_reset();
      fset(k == 0 ? 12'h040 : (k == 1 ? 12'h001 : 12'h000));
      if (k == 1)
        fset(12'h000);
      frame();
      frame();
      frame();
      chk("phase three code", k == 2 ? `CODE_READY : `CODE_DEFECT, rx.status_code);
      @(posedge core_clk);
      phase3_done <= 1'b1;
      @(posedge core_clk);
      phase3_done <= 1'b0;
      tick(2);
      frame();
      chk("run entry", k == 2, run_mode);
      chk("code after phase three", k == 2 ? 10'h0123 : `CODE_DEFECT, rx.status_code);
    end
    for (int i = 0; i < 6; i++)
    begin
      fset(fm[i]);
      frame();
      chk("fault code", cm[i], rx.status_code);
      chk("error flag", cm[i] != 10'h0123, rx.error_flag);
      chk("counter", framer_counter_bits, frame_counter_bits);
      fset(12'h000);
      frame();
      chk("recovered", 10'h0123, rx.status_code);
    end
    for (int i = 0; i < 3; i++)
    begin
      fset(12'h400 >> i);
      chk("forced line", 1'b0, link_tx_bit);
      chk("force flag", 1'b1, frame_fields.force_low);
      fset(12'h000);
      frame();
      chk("line back", 1'b1, link_tx_bit);
    end
    wr(`REG_CTRL, 8'h04);
    fset(12'h090);
    fset(12'h000);
    frame();
    chk("defect code", `CODE_DEFECT, rx.status_code);
    chk("detail", 6'h03, rx.failure_detail);
    fset(12'h800);
    chk("watchdog line", 1'b0, link_tx_bit);
    fset(12'h000);
    frame();
    chk("latched code", `CODE_DEFECT, rx.status_code);
    chk("detail sticky", 6'h13, rx.failure_detail);
    rd(`REG_LATCHED, 8'h13, "latched detail");
    wr(`REG_CTRL, 8'h14);
    frame();
    frame();
    chk("after ecu reset", 10'h0123, rx.status_code);
    rd(`REG_LATCHED, 8'h00, "detail cleared");
    rd(`REG_CTRL, 8'h04, "control");
    rd(4'h7, 8'h00, "unmapped");
    wr(`REG_CTRL, 8'h08);
    misr = 8'h00;
    for (int i = 0; i < `SIG_BYTE_COUNT; i++)
    begin
      b = 8'(i * 37 + 1);
      wr(`REG_SIG_DATA, b);
      misr = ((misr << 1) ^ b) ^ (misr[7] ? 8'h1D : 8'h00);
    end
    tick(3);
    rd(`REG_SIG_RESULT, misr, "signature");
    rd(`REG_STATUS, 8'hC7, "status");
    // a write while the clock enable is low must not land
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(`REG_CTRL, 8'h04);
    clk_en <= 1'b1;
    rd(`REG_CTRL, 8'h00, "frozen control");
    results();
  end
endmodule : tb_top

`default_nettype wire
